// File: logic/pci_trd_pkg.sv
// Shared constants and types for the target read FIFO port.
// Assumes one 40 MHz clock domain and a plain register port.
package pci_trd_pkg;

  // ************************************************
  // Register port
  // ************************************************
  localparam int REG_AW = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_QUAD_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_TERM_LSB = 12;

  // ************************************************
  // Link encodings
  // ************************************************
  localparam logic [3:0] CMD_IO_READ = 4'h2;
  localparam int WBUS_DUAL_BIT = 16;
  localparam int WBUS_BURST_BIT = 17;
  localparam int EXT_DUAL_BIT = 0;
  localparam int EXT_BURST_BIT = 1;
  localparam int AFULL_FREE64 = 4;
  localparam int SEG16_MAX = 4;
  localparam int SEG32_MAX = 2;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DRAIN} tstate_t;
  typedef enum logic [2:0] {TERM_NONE, TERM_MASTER, TERM_EMPTY, TERM_RETRY, TERM_RESET} term_t;

endpackage

// File: logic/fifo_mem_if.sv
// Port group between the FIFO control logic and its storage.
// Assumes both ends run on the same clock.
interface fifo_mem_if #(parameter int W = 32, parameter int AW = 5);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [W-1:0] rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// File: logic/fifo_mem.sv
// Storage array of the target read FIFO with registered read data.
// Assumes the caller presents next-cycle read address every cycle.
module fifo_mem #(
  parameter int W = 32,
  parameter int AW = 5
) (
  input wire logic i_clk_sys,
  fifo_mem_if.mem mem_port
);

  logic [W-1:0] store [2**AW];

  // ************************************************
  // Write and read
  // ************************************************
  // Store one word per write
  always_ff @(posedge i_clk_sys) begin
    if (mem_port.wr_en) begin
      store[mem_port.wr_addr] <= mem_port.wr_data;
    end
  end

  // Read with bypass so a word written this cycle is seen next cycle
  always_ff @(posedge i_clk_sys) begin
    if (mem_port.wr_en && mem_port.wr_addr == mem_port.rd_addr) begin
      mem_port.rd_data <= mem_port.wr_data;
    end else begin
      mem_port.rd_data <= store[mem_port.rd_addr];
    end
  end

endmodule

// File: logic/pci_target_read_fifo_port.sv
// Target read side of a PCI target FIFO interface toward user logic.
// Assumes the PCI core side signals are synchronous to i_clk_sys.
//
// The register offsets and strobed register access were left to the implementer.
module pci_target_read_fifo_port #(
  parameter int DEPTH64 = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [pci_trd_pkg::REG_AW-1:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire logic i_pci_rst_n,
  input wire logic i_pci_accept,
  input wire logic [3:0] i_pci_cmd,
  input wire logic [63:0] i_pci_addr,
  input wire logic i_pci_burst,
  input wire logic i_pci_dual,
  input wire logic [2:0] i_pci_region,
  input wire logic [6:0] i_pci_region_bits,
  input wire logic i_pci_take,
  input wire logic i_pci_data_wait,
  input wire logic i_pci_master_end,
  input wire logic i_pci_other_pending,
  output logic o_pci_trdy,
  output logic o_pci_stop,
  output logic [31:0] o_pci_data,
  output logic o_treq_n,
  output logic o_t_alive_n,
  output logic [3:0] o_cmd,
  output logic [2:0] o_region,
  input wire logic i_addr_en_n,
  input wire logic i_fifo_sel,
  output logic [17:0] o_wbus,
  output logic [31:0] o_addr_data,
  output logic [3:0] o_addr_ext,
  output logic o_lastcyc_w_n,
  input wire logic i_rdata_en_n,
  input wire logic [31:0] i_rdata32,
  input wire logic [15:0] i_rdata16,
  output logic o_lastcyc_r_n,
  output logic o_read_fifo_full_n,
  output logic o_read_fifo_almost_full_n,
  input wire logic i_read_hold_n,
  input wire logic i_fifo_clear_n
);
  import pci_trd_pkg::*;

  localparam int WORDS = 2 * DEPTH64;
  localparam int AW = $clog2(WORDS);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(WORDS);
  localparam logic [AW:0] AFULL_CNT = (AW+1)'(WORDS - 2 * AFULL_FREE64);

  // ************************************************
  // Reset release and FIFO clear synchroniser
  // ************************************************
  logic rst_q1, rst_n, clr_q1, clr_q2;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // Two-flop copy of the asynchronous clear input
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clr_q1 <= 1'b1;
      clr_q2 <= 1'b1;
    end else begin
      clr_q1 <= i_fifo_clear_n;
      clr_q2 <= clr_q1;
    end
  end

  // ************************************************
  // Declarations and datapath helpers
  // ************************************************
  tstate_t state, next_state;
  term_t term;
  logic wide, quad;
  logic [63:0] addr_q;
  logic [2:0] acyc, ncyc;
  logic burst_q, dual_q, io_q, single_q, skip_first, took_any, half_sel;
  logic [15:0] half_lo;
  logic [AW-1:0] wr_ptr, rd_ptr, next_rd;
  logic [AW:0] count, next_count;
  logic [7:0] seg16_n, seg32_n;
  wire clr = !clr_q2;
  wire abort = clr || !i_pci_rst_n;
  wire en_a = state == ST_ADDR && !i_addr_en_n && !o_t_alive_n;
  wire en_d = !i_rdata_en_n && (state == ST_DATA || state == ST_DRAIN);
  wire word_done = en_d && (!quad || half_sel);
  wire [31:0] word = quad ? {i_rdata16, half_lo} : i_rdata32;
  wire push = word_done && state == ST_DATA && !skip_first && count != FULL_CNT;
  wire pop = i_pci_take && o_pci_trdy;
  wire end_master = (state == ST_ADDR || state == ST_DATA) && i_pci_master_end;
  wire end_io = state == ST_DATA && io_q && pop;
  wire end_empty = state == ST_DATA && took_any && i_pci_data_wait && next_count == '0;
  wire end_retry = state == ST_DATA && !took_any && i_pci_other_pending && !o_pci_trdy;
  wire term_any = end_master || end_io || end_empty || end_retry;
  wire last_seg = acyc == ncyc - 3'h1;
  fifo_mem_if #(.W(32), .AW(AW)) mif ();

  // Address cycles needed for the decoded region size
  always_comb begin
    seg16_n = (8'(i_pci_region_bits) + 8'h0F) >> 4;
    seg32_n = (8'(i_pci_region_bits) + 8'h1F) >> 5;
    if (seg16_n == 8'h00) seg16_n = 8'h01;
    if (seg32_n == 8'h00) seg32_n = 8'h01;
    if (seg16_n > 8'(SEG16_MAX)) seg16_n = 8'(SEG16_MAX);
    if (seg32_n > 8'(SEG32_MAX)) seg32_n = 8'(SEG32_MAX);
  end

  // Occupancy and pointers; termination flushes what is left
  always_comb begin
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_rd = rd_ptr + AW'(pop);
    if (term_any || abort) begin
      next_count = '0;
      next_rd = wr_ptr + AW'(push);
    end
  end

  assign mif.wr_en = push;
  assign mif.wr_addr = wr_ptr;
  assign mif.wr_data = word;
  assign mif.rd_addr = next_rd;

  fifo_mem #(.W(32), .AW(AW)) u_mem (
    .i_clk_sys(i_clk_sys),
    .mem_port(mif)
  );
  assign o_pci_data = mif.rd_data;

  // ************************************************
  // Transaction state
  // ************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (i_pci_accept) next_state = ST_ADDR;
      ST_ADDR: begin
        if (end_master) next_state = ST_DRAIN;
        else if (en_a && last_seg) next_state = ST_DATA;
      end
      ST_DATA: if (term_any) next_state = ST_DRAIN;
      ST_DRAIN: if (en_d) next_state = ST_IDLE;
    endcase
    if (abort) next_state = ST_IDLE;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request stays low through drain and rises once the interface is idle
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_treq_n <= 1'b1;
      o_t_alive_n <= 1'b1;
    end else begin
      o_treq_n <= next_state == ST_IDLE;
      o_t_alive_n <= !(next_state == ST_ADDR || next_state == ST_DATA);
    end
  end

  // Cause of the last termination
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      term <= TERM_NONE;
    end else if (!i_pci_rst_n) begin
      term <= TERM_RESET;
    end else if (end_master || end_io) begin
      term <= TERM_MASTER;
    end else if (end_empty) begin
      term <= TERM_EMPTY;
    end else if (end_retry) begin
      term <= TERM_RETRY;
    end
  end

  // ************************************************
  // Command/address phase
  // ************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      burst_q <= 1'b0;
      dual_q <= 1'b0;
      io_q <= 1'b0;
      single_q <= 1'b0;
      skip_first <= 1'b0;
      ncyc <= 3'h1;
      o_cmd <= 4'h0;
      o_region <= 3'h0;
    end else if (state == ST_IDLE && i_pci_accept) begin
      addr_q <= i_pci_addr;
      burst_q <= i_pci_burst;
      dual_q <= i_pci_dual;
      io_q <= i_pci_cmd == CMD_IO_READ;
      single_q <= !i_pci_burst && !wide;
      skip_first <= (i_pci_burst || wide) && i_pci_addr[2];
      ncyc <= quad ? seg16_n[2:0] : seg32_n[2:0];
      o_cmd <= i_pci_cmd;
      o_region <= i_pci_region;
    end else if (word_done && state == ST_DATA) begin
      skip_first <= 1'b0;
    end
  end

  // Segment index and registered address buses
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acyc <= 3'h0;
      o_wbus <= '0;
      o_addr_data <= '0;
      o_addr_ext <= '0;
      o_lastcyc_w_n <= 1'b1;
    end else if (next_state == ST_ADDR) begin
      automatic logic [2:0] idx = (state == ST_ADDR && en_a) ? acyc + 3'h1 : 3'h0;
      automatic logic [63:0] a = (state == ST_ADDR) ? addr_q : i_pci_addr;
      automatic logic bflag = (state == ST_ADDR) ? burst_q : i_pci_burst;
      automatic logic dflag = (state == ST_ADDR) ? dual_q : i_pci_dual;
      automatic logic [2:0] n = (state == ST_ADDR) ? ncyc
                                : (quad ? seg16_n[2:0] : seg32_n[2:0]);
      acyc <= idx;
      o_wbus <= quad ? {bflag, dflag, a[16*idx[1:0] +: 16]} : '0;
      o_addr_data <= (!quad && i_fifo_sel) ? a[32*idx[0] +: 32] : '0;
      o_addr_ext <= quad ? 4'h0 : {2'h0, bflag, dflag};
      o_lastcyc_w_n <= idx != n - 3'h1;
    end else begin
      acyc <= 3'h0;
      o_wbus <= '0;
      o_addr_data <= '0;
      o_addr_ext <= '0;
      o_lastcyc_w_n <= 1'b1;
    end
  end

  // ************************************************
  // Read data phase
  // ************************************************
  // Half-word assembly in quad mode, low half first
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_sel <= 1'b0;
      half_lo <= '0;
    end else if (next_state == ST_IDLE || next_state == ST_ADDR) begin
      half_sel <= 1'b0;
    end else if (en_d && quad) begin
      half_sel <= !half_sel;
      if (!half_sel) half_lo <= i_rdata16;
    end
  end

  // FIFO pointers and occupancy
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= next_rd;
      count <= next_count;
    end
  end

  // Full flags follow the occupancy of the coming cycle
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_read_fifo_full_n <= 1'b1;
      o_read_fifo_almost_full_n <= 1'b1;
    end else begin
      o_read_fifo_full_n <= next_count != FULL_CNT;
      o_read_fifo_almost_full_n <= next_count < AFULL_CNT;
    end
  end

  // Last-cycle read flag answers a sampled data enable
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_lastcyc_r_n <= 1'b1;
    end else begin
      o_lastcyc_r_n <= !((state == ST_DRAIN && en_d)
                         || (state == ST_DATA && single_q && word_done && !abort));
    end
  end

  // ************************************************
  // PCI side ready and stop
  // ************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_pci_trdy <= 1'b0;
      o_pci_stop <= 1'b0;
      took_any <= 1'b0;
    end else begin
      automatic logic rdy = next_state == ST_DATA && next_count != '0
                            && (i_read_hold_n || next_count == FULL_CNT);
      o_pci_trdy <= rdy;
      o_pci_stop <= (rdy && io_q) || end_empty || end_retry;
      if (next_state != ST_DATA) took_any <= 1'b0;
      else if (pop) took_any <= 1'b1;
    end
  end

  // ************************************************
  // Register port
  // ************************************************
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wide <= CTRL_RESET[CTRL_WIDE_BIT];
      quad <= CTRL_RESET[CTRL_QUAD_BIT];
    end else if (i_reg_wr && i_reg_addr == CTRL_OFS) begin
      wide <= i_reg_wdata[CTRL_WIDE_BIT];
      quad <= i_reg_wdata[CTRL_QUAD_BIT];
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= '0;
      if (i_reg_addr == CTRL_OFS) begin
        o_reg_rdata[CTRL_WIDE_BIT] <= wide;
        o_reg_rdata[CTRL_QUAD_BIT] <= quad;
      end else if (i_reg_addr == STAT_OFS) begin
        o_reg_rdata[STAT_COUNT_LSB +: AW+1] <= count;
        o_reg_rdata[STAT_STATE_LSB +: 2] <= state;
        o_reg_rdata[STAT_TERM_LSB +: 3] <= term;
      end
    end else begin
      o_reg_rdata <= '0;
    end
  end

endmodule

// File: verification/trd_port_checker.sv
// Concurrent checks on the pins of the target read FIFO port.
// Assumes one clock domain and binding to every port instance.
module trd_port_checker
  import pci_trd_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_pci_accept,
  input wire logic i_rdata_en_n,
  input wire logic i_read_hold_n,
  input wire logic o_pci_trdy,
  input wire logic o_pci_stop,
  input wire logic o_treq_n,
  input wire logic o_t_alive_n,
  input wire logic [3:0] o_cmd,
  input wire logic [2:0] o_region,
  input wire logic o_lastcyc_w_n,
  input wire logic o_lastcyc_r_n,
  input wire logic o_read_fifo_full_n,
  input wire logic o_read_fifo_almost_full_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Pin relations
  // ****************
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  // Each check ties an output to an input that causes it or to another output that it must agree with
  last_rd_a: assert property (!o_lastcyc_r_n |-> $past(!i_rdata_en_n))
    else $error("read last flag without data enable");
  alive_req_a: assert property (!o_t_alive_n |-> !o_treq_n)
    else $error("alive while request idle");
  full_afull_a: assert property (!o_read_fifo_full_n |-> !o_read_fifo_almost_full_n)
    else $error("full without almost full");
  tag_stable_a: assert property (!o_treq_n && $past(!o_treq_n) && !$past(i_pci_accept)
    |-> $stable({o_cmd, o_region}))
    else $error("command or region moved during request");
  last_wr_a: assert property (!o_lastcyc_w_n |-> !o_treq_n)
    else $error("address last flag while idle");
  req_up_a: assert property (i_pci_accept && o_treq_n |=> !o_treq_n)
    else $error("accepted transfer not announced");
  io_stop_a: assert property (o_pci_trdy && !o_treq_n && o_cmd == CMD_IO_READ |-> o_pci_stop)
    else $error("io read word without disconnect");
  hold_rdy_a: assert property (!i_read_hold_n && $past(!i_read_hold_n) &&
    o_read_fifo_full_n && $past(o_read_fifo_full_n) |-> !o_pci_trdy)
    else $error("ready during hold before full");
  idle_room_a: assert property (o_treq_n && $past(o_treq_n)
    |-> o_read_fifo_almost_full_n)
    else $error("almost full while idle");
endmodule

bind pci_target_read_fifo_port trd_port_checker chk_u (.i_clk_sys, .i_nrst, .i_pci_accept,
  .i_rdata_en_n, .i_read_hold_n, .o_pci_trdy, .o_pci_stop, .o_treq_n, .o_t_alive_n, .o_cmd,
  .o_region, .o_lastcyc_w_n, .o_lastcyc_r_n, .o_read_fifo_full_n, .o_read_fifo_almost_full_n);

// File: verification/user_app_model.sv
// Behavioural user logic that serves target read requests.
// Assumes it shares clock and reset with the port; word k is base plus k.
module user_app_model (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_quad,
  input wire logic [31:0] i_base,
  input wire logic i_treq_n,
  input wire logic i_t_alive_n,
  input wire logic i_lastcyc_w_n,
  input wire logic i_lastcyc_r_n,
  input wire logic i_full_n,
  output logic o_addr_en_n,
  output logic o_fifo_sel,
  output logic o_rdata_en_n,
  output logic [31:0] o_rdata32,
  output logic [15:0] o_rdata16
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Request service
  // ****************
  logic [1:0] ph; // 0 address, 1 data, 2 drain, 3 wait idle
  logic stop, hi;
  logic [31:0] k;

  // Enables are active low and follow registered port outputs
  assign o_addr_en_n = !(ph == 2'h0 && !i_treq_n && !i_t_alive_n);
  assign o_fifo_sel = ph == 2'h0; // Held up early so the registered address bus loads
  assign o_rdata_en_n = !(((ph == 2'h1 && !stop) || ph == 2'h2) && i_full_n);
  // Idle data lines carry the inverse so stale values never match
  assign o_rdata32 = o_rdata_en_n ? ~(i_base + k) : i_base + k;
  assign o_rdata16 = hi ? o_rdata32[31:16] : o_rdata32[15:0];

  // Phase and word counter; a quad word takes two enables
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      ph <= 2'h0;
      stop <= 1'b0;
      hi <= 1'b0;
      k <= 32'h0;
    end else begin
      if (!o_rdata_en_n) begin
        hi <= i_quad && !hi;
        k <= k + ((!i_quad || hi) ? 32'h1 : 32'h0);
      end
      case (ph)
        2'h0: begin
          if (!i_treq_n && i_t_alive_n) ph <= 2'h2;
          else if (!o_addr_en_n && !i_lastcyc_w_n) ph <= 2'h1;
        end
        2'h1: begin
          if (i_t_alive_n) ph <= 2'h2;
          if (!i_lastcyc_r_n) stop <= 1'b1;
        end
        2'h2: ph <= o_rdata_en_n ? ph : 2'h3;
        default: if (i_treq_n) begin
          ph <= 2'h0;
          stop <= 1'b0;
          hi <= 1'b0;
          k <= 32'h0;
        end
      endcase
    end
  end
endmodule

// File: verification/tb_top.sv
// Self-checking bench: register port, address phase, read data, terminations.
// Assumes package, design, checker and user model are compiled before it.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pci_trd_pkg::*;

  // ****************
  // Signals and model
  // ****************
  logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_pci_rst_n = 1'b1;
  logic i_pci_accept = 1'b0, i_pci_burst = 1'b0, i_pci_dual = 1'b0, i_pci_take = 1'b0;
  logic i_pci_data_wait = 1'b0, i_pci_master_end = 1'b0, i_pci_other_pending = 1'b0;
  logic i_read_hold_n = 1'b1, i_fifo_clear_n = 1'b1, q = 1'b0, full_seen = 1'b0;
  logic [3:0] i_reg_addr = 4'h0, i_pci_cmd = 4'h0, o_cmd, o_addr_ext;
  logic [31:0] i_reg_wdata = 32'h0, base = 32'h0, o_reg_rdata, o_pci_data, o_addr_data, i_rdata32;
  logic [63:0] i_pci_addr = 64'h0;
  logic [2:0] i_pci_region = 3'h0, o_region;
  logic [6:0] i_pci_region_bits = 7'h0;
  logic [17:0] o_wbus;
  logic [15:0] i_rdata16;
  logic o_pci_trdy, o_pci_stop, o_treq_n, o_t_alive_n, o_lastcyc_w_n, o_lastcyc_r_n;
  logic i_addr_en_n, i_fifo_sel, i_rdata_en_n, o_read_fifo_full_n, o_read_fifo_almost_full_n;
  int seed = 18, checked = 0, error_cnt = 0;
  logic [31:0] exp_q[$];
  logic [33:0] seg_q[$];
  // Case fields: [27:24] term (F unchecked) [22:16] region bits [15:12] words taken
  // [11:8] command [6] bus reset [5] other pending [4] odd start [3] dual [2] burst
  // [1] wide [0] quad
  logic [31:0] cases [8] = '{32'h0112_1600, 32'h0112_1611, 32'h0128_561C, 32'h0114_6C05,
    32'h0F08_1200, 32'h0112_1612, 32'h0312_0620, 32'h0412_0644};

  always #12.5 i_clk_sys = ~i_clk_sys;

  pci_target_read_fifo_port #(.DEPTH64(8)) dut_u (.i_clk_sys, .i_nrst, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_pci_rst_n, .i_pci_accept, .i_pci_cmd, .i_pci_addr,
    .i_pci_burst, .i_pci_dual, .i_pci_region, .i_pci_region_bits, .i_pci_take, .i_pci_data_wait,
    .i_pci_master_end, .i_pci_other_pending, .o_pci_trdy, .o_pci_stop, .o_pci_data, .o_treq_n,
    .o_t_alive_n, .o_cmd, .o_region, .i_addr_en_n, .i_fifo_sel, .o_wbus, .o_addr_data,
    .o_addr_ext, .o_lastcyc_w_n, .i_rdata_en_n, .i_rdata32, .i_rdata16, .o_lastcyc_r_n,
    .o_read_fifo_full_n, .o_read_fifo_almost_full_n, .i_read_hold_n, .i_fifo_clear_n);

  user_app_model usr_u (.i_clk_sys, .i_nrst, .i_quad(q), .i_base(base), .i_treq_n(o_treq_n),
    .i_t_alive_n(o_t_alive_n), .i_lastcyc_w_n(o_lastcyc_w_n), .i_lastcyc_r_n(o_lastcyc_r_n),
    .i_full_n(o_read_fifo_full_n), .o_addr_en_n(i_addr_en_n), .o_fifo_sel(i_fifo_sel),
    .o_rdata_en_n(i_rdata_en_n), .o_rdata32(i_rdata32), .o_rdata16(i_rdata16));

  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected address at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1 cmp_word(o_reg_rdata & m, exp & m);
  endtask

  // PCI master side: address segments, taken words, end pulse, hold release at full
  always @(posedge i_clk_sys) begin
    if (!i_addr_en_n) begin
      cmp_bus(q ? {16'h0, o_wbus} : {o_addr_ext[1:0], o_addr_data},
              seg_q.pop_front());
      cmp_word({25'h0, o_cmd, o_region}, {25'h0, i_pci_cmd, i_pci_region});
    end
    if (i_pci_take && o_pci_trdy) begin
      cmp_word(o_pci_data, exp_q.pop_front());
      if (exp_q.size() == 0) begin
        i_pci_take <= 1'b0;
        i_pci_master_end <= 1'b1;
      end
    end
    if (i_pci_master_end) i_pci_master_end <= 1'b0;
    if (!o_read_fifo_full_n) begin
      full_seen <= 1'b1;
      i_read_hold_n <= 1'b1;
    end
  end

  // One target read: expectations first, then accept and wait for the request to end
  task automatic run(input int c);
    logic [31:0] k;
    logic [63:0] a, x;
    int i, w;
    k = cases[c];
    q = k[0];
    w = k[0] ? 16 : 32;
    wr(CTRL_OFS, {30'h0, k[0], k[1]});
    a = {$random(seed), $random(seed)} & ((64'h1 << k[22:16]) - 64'h1) & ~64'h7 | {k[4], 2'h0};
    base = $random(seed);
    for (i = 0; i < (k[22:16] + w - 1) / w; i++) begin
      x = a >> (i * w);
      seg_q.push_back(k[0] ? {16'h0, k[2], k[3], x[15:0]} : {k[2], k[3], x[31:0]});
    end
    for (i = 0; i < k[15:12]; i++) exp_q.push_back(base + (k[4] & (k[2] | k[1])) + i);
    @(posedge i_clk_sys);
    i_pci_accept <= 1'b1;
    i_pci_cmd <= k[11:8];
    i_pci_addr <= a;
    i_pci_burst <= k[2];
    i_pci_dual <= k[3];
    i_pci_region <= 3'($random(seed));
    i_pci_region_bits <= k[22:16];
    i_pci_other_pending <= k[5];
    i_read_hold_n <= !k[2];
    i_pci_data_wait <= 1'b1;
    i_pci_take <= k[15:12] != 4'h0;
    full_seen <= 1'b0;
    @(posedge i_clk_sys);
    i_pci_accept <= 1'b0;
    for (i = 0; i < 500 && k[6] && full_seen !== 1'b1; i++) @(posedge i_clk_sys);
    if (k[6]) begin
      i_pci_rst_n <= 1'b0;
      @(posedge i_clk_sys);
      i_pci_rst_n <= 1'b1;
    end
    repeat (2) @(posedge i_clk_sys);
    for (i = 0; i < 500 && o_treq_n !== 1'b1; i++) @(posedge i_clk_sys);
    cmp_word(o_treq_n, 1'b1);
    cmp_word(exp_q.size(), 32'h0);
    i_pci_other_pending <= 1'b0;
    i_pci_data_wait <= 1'b0;
    i_read_hold_n <= 1'b1;
    cmp_word(seg_q.size(), 32'h0);
    cmp_word(full_seen, k[2]);
    repeat (3) @(posedge i_clk_sys);
    rd(STAT_OFS, {k[27:24], 12'h0}, k[27:24] == 4'hF ? 32'h3FF : 32'hFFFF);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence: registers, every case of the table, then a FIFO clear
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    rd(CTRL_OFS, 32'h0, 32'hFFFFFFFF);
    rd(STAT_OFS, 32'h0, 32'hFFFFFFFF);
    wr(4'h8, 32'hFFFFFFFF);
    rd(4'h8, 32'h0, 32'hFFFFFFFF);
    wr(CTRL_OFS, 32'h3);
    rd(CTRL_OFS, 32'h3, 32'hFFFFFFFF);
    for (int c = 0; c < 8; c++) run(c);
    @(posedge i_clk_sys);
    i_fifo_clear_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_fifo_clear_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    rd(STAT_OFS, 32'h0, 32'h3FF);
    run(3);
    test_done;
  end

  // Watchdog far beyond the expected run of a few hundred cycles
  initial begin
    #500000;
    error_cnt++;
    test_done;
  end
endmodule
